//--- rtl/ddmr_mode_burst.sv
// mode-register store and burst column sequencer of the memory device
// assumes command pins synchronous to i_mclk; bank state comes from outside
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - all-low command with bank 00 loads main
// - fields: length, order, read latency, no halves
// - test bit kept; A8 high pulses dll reset
// - A9-A11 hold store recovery count
// - total delay is recovery plus precharge period
// - only four or eight beat bursts accepted
// - eight-beat sequential wraps per nibble
// - order follows programmed order bit
// - four-beat order wraps or xors start
// - eight-beat order per nibble or xor
// - back-to-back bursts run without gaps
// - eight-beat read by read, write by write
// - burst terminate is not supported
// - bank 01 command loads extended register one
// - rewrites allowed only when all precharged
module ddmr_mode_burst
    import ddmr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [1:0] i_ba,
    input wire logic [12:0] i_addr,
    input wire logic i_all_precharged,
    output logic [12:0] o_main_cfg_reg,
    output logic [12:0] o_extended_cfg_one,
    output logic o_burst_len8,
    output logic o_burst_order_sel,
    output logic [2:0] o_read_latency,
    output logic o_cfg_valid,
    output logic o_test_select,
    output logic o_powerdown_exit_sel,
    output logic [3:0] o_pd_exit_delay,
    output logic [3:0] o_store_recovery_clks,
    output logic [4:0] o_autoprecharge_total_delay,
    output logic o_dll_reset_req,
    output logic o_beat_valid,
    output logic o_beat_write,
    output logic [2:0] o_col_even,
    output logic [2:0] o_col_odd,
    output logic o_cmd_refused
);
    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire logic sel = i_cke & ~i_cs_n;
    wire logic mode_cmd = sel & ~i_ras_n & ~i_cas_n & ~i_we_n;
    wire logic col_cmd = sel & i_ras_n & ~i_cas_n;
    wire logic rd_cmd = col_cmd & i_we_n;
    wire logic wr_cmd = col_cmd & ~i_we_n;
    wire logic stop_cmd = sel & i_ras_n & i_cas_n & ~i_we_n;

    logic [12:0] main_q, main_d, ext1_q, ext1_d;
    ddmr_state_t state_q, state_d;
    logic [1:0] pair_q, pair_d;
    logic [2:0] start_q, start_d;
    logic len8_q, len8_d, order_q, order_d;
    logic dll_q, refused_q, refused_d;
    logic [2:0] col_q [2];

    wire logic [2:0] bl_code = main_q[BL_LSB +: 3];
    wire logic [2:0] cl_code = main_q[CL_LSB +: 3];
    wire logic [2:0] wr_code = main_q[WR_LSB +: 3];
    wire logic bl_ok = (bl_code == BL4_CODE) || (bl_code == BL8_CODE);
    wire logic cl_ok = cl_code >= CL_MIN_CODE;
    wire logic wr_ok = (wr_code >= WR_MIN_CODE) && (wr_code <= WR_MAX_CODE);

    // ----------------------------------------------------------------
    // mode register writes
    // ----------------------------------------------------------------
    // banks must be idle; a write mid-burst would retime the burst in flight
    wire logic mode_ok = mode_cmd & i_all_precharged & (state_q == DDMR_IDLE);
    wire logic main_wr = mode_ok & (i_ba == BA_MAIN_CFG);
    wire logic ext1_wr = mode_ok & (i_ba == BA_EXT_ONE);
    assign main_d = main_wr ? i_addr : main_q;
    assign ext1_d = ext1_wr ? i_addr : ext1_q;

    // ----------------------------------------------------------------
    // burst sequencing, two beats per clock
    // ----------------------------------------------------------------
    wire logic busy = state_q != DDMR_IDLE;
    wire logic last = busy && (pair_q == (len8_q ? BL8_LAST_PAIR : BL4_LAST_PAIR));
    wire logic same = (rd_cmd && state_q == DDMR_READ) || (wr_cmd && state_q == DDMR_WRITE);
    // new burst on the last pair keeps the flow gapless
    wire logic col_ok = col_cmd & bl_ok & (!busy | last | (len8_q & same));
    wire logic done = last & ~col_ok;

    always_comb begin
        state_d = state_q;
        pair_d = pair_q + 2'h1;
        start_d = start_q;
        len8_d = len8_q;
        order_d = order_q;
        if (col_ok) begin
            state_d = rd_cmd ? DDMR_READ : DDMR_WRITE;
            pair_d = 2'h0;
            start_d = i_addr[2:0];
            len8_d = bl_code == BL8_CODE;
            order_d = main_q[ORDER_BIT];
        end else if (done || !busy) begin
            state_d = DDMR_IDLE;
            pair_d = 2'h0;
        end
    end

    // stop is decoded but never acted on, so it is refused like any illegal command
    assign refused_d = stop_cmd | (col_cmd & ~col_ok) | (mode_cmd & ~mode_ok);

    genvar ln;
    generate
        for (ln = 0; ln < 2; ln++) begin : g_lane
            wire logic [2:0] beat = {pair_d, 1'(ln)};
            // sequential wraps inside the nibble, interleave xors the whole index
            wire logic [2:0] seq = {start_d[2] ^ beat[2], start_d[1:0] + beat[1:0]};
            wire logic [2:0] col_d = order_d ? (start_d ^ beat) : seq;
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    col_q[ln] <= 3'h0;
                end else begin
                    col_q[ln] <= col_d;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            main_q <= CFG_RST;
            ext1_q <= CFG_RST;
            state_q <= DDMR_IDLE;
            pair_q <= 2'h0;
            start_q <= 3'h0;
            len8_q <= 1'b0;
            order_q <= 1'b0;
            dll_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            main_q <= main_d;
            ext1_q <= ext1_d;
            state_q <= state_d;
            pair_q <= pair_d;
            start_q <= start_d;
            len8_q <= len8_d;
            order_q <= order_d;
            dll_q <= main_wr & i_addr[DLL_RST_BIT];
            refused_q <= refused_d;
        end
    end

    // ----------------------------------------------------------------
    // decoded settings
    // ----------------------------------------------------------------
    assign o_main_cfg_reg = main_q;
    assign o_extended_cfg_one = ext1_q;
    assign o_burst_len8 = bl_code == BL8_CODE;
    assign o_burst_order_sel = main_q[ORDER_BIT];
    assign o_read_latency = cl_code;
    assign o_cfg_valid = bl_ok & cl_ok & wr_ok & ~main_q[TEST_BIT];
    assign o_test_select = main_q[TEST_BIT];
    assign o_powerdown_exit_sel = main_q[PD_BIT];
    assign o_pd_exit_delay = main_q[PD_BIT] ? SLOW_PD_EXIT_DELAY : FAST_PD_EXIT_DELAY;
    assign o_store_recovery_clks = {1'b0, wr_code} + 4'h1;
    assign o_autoprecharge_total_delay = {1'b0, o_store_recovery_clks} + {1'b0, PRECHARGE_PERIOD};
    assign o_dll_reset_req = dll_q;
    assign o_beat_valid = busy;
    assign o_beat_write = state_q == DDMR_WRITE;
    assign o_col_even = col_q[0];
    assign o_col_odd = col_q[1];
    assign o_cmd_refused = refused_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    main_load_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        main_wr |=> o_main_cfg_reg == $past(i_addr)) else $error("main register not loaded");
    ext_load_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        ext1_wr |=> o_extended_cfg_one == $past(i_addr)) else $error("extended register not loaded");
    busy_write_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (mode_cmd && !i_all_precharged) |=> $stable(o_main_cfg_reg) && o_cmd_refused)
        else $error("mode write taken with open banks");
    dll_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (main_wr && i_addr[DLL_RST_BIT]) |=> o_dll_reset_req ##1 !o_dll_reset_req)
        else $error("dll reset request not a pulse");
    total_delay_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_autoprecharge_total_delay == 5'(wr_code) + 5'h1 + 5'(PRECHARGE_PERIOD))
        else $error("total delay sum wrong");
    bl4_span_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (col_ok && bl_code == BL4_CODE) |=> o_beat_valid[*2]) else $error("four-beat burst cut short");
    lane_pair_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_beat_valid |-> o_col_odd == (order_q ? (o_col_even ^ 3'h1)
                                               : {o_col_even[2], o_col_even[1:0] + 2'h1}))
        else $error("odd lane out of order");
    // per-cycle form so a legal read-by-read restart cannot trip it
    nibble_wrap_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (o_beat_valid && len8_q && !order_q && start_q == 3'h1)
        |-> (o_col_even == {pair_q, 1'b1}) && (pair_q != BL8_LAST_PAIR || o_col_odd == 3'h4))
        else $error("nibble sequence wrong");
    stop_refused_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        stop_cmd |=> o_cmd_refused) else $error("burst stop not refused");
    cross_refused_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (wr_cmd && state_q == DDMR_READ && !last) |=> o_cmd_refused && !o_beat_write)
        else $error("write interrupted a read");
    seamless_flow_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (last && col_ok) |=> o_beat_valid) else $error("gap between bursts");

    interrupt_c: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        busy && !last && col_ok);
    seamless_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) last && col_ok);
    mode_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) main_wr ##[1:20] col_ok);
    interleave_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_beat_valid && order_q);
endmodule
`default_nettype wire

//--- rtl/ddmr_pkg.sv
// constants for the mode-register decode and burst column sequencer
// assumes a single device clock; no bus, all settings travel as ports
`default_nettype none
package ddmr_pkg;
    // ----------------------------------------------------------------
    // command decode values
    // ----------------------------------------------------------------
    localparam logic [1:0] BA_MAIN_CFG = 2'h0;
    localparam logic [1:0] BA_EXT_ONE = 2'h1;
    // ----------------------------------------------------------------
    // main_cfg_reg field positions
    // ----------------------------------------------------------------
    localparam int BL_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int TEST_BIT = 7;
    localparam int DLL_RST_BIT = 8;
    localparam int WR_LSB = 9;
    localparam int PD_BIT = 12;
    // ----------------------------------------------------------------
    // field codes and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] BL4_CODE = 3'h2;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] CL_MIN_CODE = 3'h3;
    localparam logic [2:0] WR_MIN_CODE = 3'h1;
    localparam logic [2:0] WR_MAX_CODE = 3'h5;
    localparam logic [12:0] CFG_RST = 13'h0000;
    localparam logic [1:0] BL4_LAST_PAIR = 2'h1;
    localparam logic [1:0] BL8_LAST_PAIR = 2'h3;
    // ----------------------------------------------------------------
    // timing in clocks (plain defaults)
    // ----------------------------------------------------------------
    localparam logic [3:0] PRECHARGE_PERIOD = 4'h4;
    localparam logic [3:0] FAST_PD_EXIT_DELAY = 4'h2;
    localparam logic [3:0] SLOW_PD_EXIT_DELAY = 4'h6;

    typedef enum logic [1:0] {DDMR_IDLE, DDMR_READ, DDMR_WRITE} ddmr_state_t;
endpackage
`default_nettype wire

//--- testbench/ddmr_ctrl_model.sv
// controller model driving the command pins
// assumes issue starts just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module ddmr_ctrl_model (
    input wire logic i_mclk,
    output logic [3:0] o_cmd,
    output logic [1:0] o_ba,
    output logic [12:0] o_addr
);
    initial begin
        o_cmd = 4'hf;
        o_ba = 2'h0;
        o_addr = 13'h0000;
    end
    task automatic issue(input logic [2:0] rcw, input logic [1:0] ba, input logic [12:0] a);
        o_cmd = {1'b0, rcw};
        o_ba = ba;
        o_addr = a;
        @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    // pins keep the command until the next issue or idle, one change per edge
    task automatic idle();
        o_cmd = 4'hf; // deselected: junk, never the old value
        o_ba = ~o_ba;
        o_addr = ~o_addr;
        @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_ddmr_mode_burst.sv
// bench for mode-register store and burst sequencer
// assumes ddmr_ctrl_model on the pins, 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_ddmr_mode_burst;
    import ddmr_pkg::*;
    typedef struct packed {logic [12:0] a; logic ok;} ddmr_row_t;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic cke = 1'b1;
    logic prech = 1'b1;
    logic len8, order, cfg_ok, tsel, pdsel, dll, bv, bw, refused;
    logic [2:0] lat, col_e, col_o;
    logic [3:0] cp, pd_dly, rec;
    logic [1:0] ba;
    logic [12:0] addr, main_q, ext_q;
    logic [4:0] tot;
    int bad_count = 0;
    int total_checks = 0;
    ddmr_row_t rows [8] = '{'{13'h0232, 1'b1}, '{13'h1a7b, 1'b1}, '{13'h0c42, 1'b0}, '{13'h0222, 1'b0},
        '{13'h02b3, 1'b0}, '{13'h0032, 1'b0}, '{13'h0e33, 1'b0}, '{13'h0231, 1'b0}};
    always #20 i_mclk = ~i_mclk;
    ddmr_ctrl_model u_ddmr_ctrl_model (.i_mclk(i_mclk), .o_cmd(cp), .o_ba(ba), .o_addr(addr));
    ddmr_mode_burst u_ddmr_mode_burst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cke(cke), .i_cs_n(cp[3]),
        .i_ras_n(cp[2]), .i_cas_n(cp[1]), .i_we_n(cp[0]), .i_ba(ba), .i_addr(addr), .i_all_precharged(prech),
        .o_main_cfg_reg(main_q), .o_extended_cfg_one(ext_q), .o_burst_len8(len8), .o_burst_order_sel(order),
        .o_read_latency(lat), .o_cfg_valid(cfg_ok), .o_test_select(tsel), .o_powerdown_exit_sel(pdsel),
        .o_pd_exit_delay(pd_dly), .o_store_recovery_clks(rec), .o_autoprecharge_total_delay(tot),
        .o_dll_reset_req(dll), .o_beat_valid(bv), .o_beat_write(bw), .o_col_even(col_e),
        .o_col_odd(col_o), .o_cmd_refused(refused));
    task automatic cmd(input logic [2:0] r, input logic [1:0] b, input logic [12:0] a);
        u_ddmr_ctrl_model.issue(r, b, a);
    endtask
    task automatic setup(input logic l8, input logic il);
        // recovery code 001: store_recovery_ns rounded up to 2 clocks
        cmd(3'h0, BA_MAIN_CFG, {9'h023, il, 2'h1, l8});
        u_ddmr_ctrl_model.idle();
    endtask
    function automatic logic [2:0] col(input logic il, input logic [2:0] s, input logic [2:0] b);
        return il ? s ^ b : {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction
    task automatic burst(input logic wr, input logic il, input logic [2:0] s, input int pairs);
        cmd({2'h2, ~wr}, 2'h0, {10'h000, s});
        for (int p = 0; p < pairs; p++) begin
            if (p > 0) u_ddmr_ctrl_model.idle();
            `CHK(bv, 1'b1)
            `CHK(bw, wr)
            `CHK(col_e, col(il, s, 3'(2 * p)))
            `CHK(col_o, col(il, s, 3'(2 * p + 1)))
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_mclk);
        `CHK(main_q, CFG_RST)
        `CHK(tot, 5'h5)
        i_resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            cmd(3'h0, BA_MAIN_CFG, rows[i].a);
            `CHK(main_q, rows[i].a)
            `CHK(cfg_ok, rows[i].ok)
            `CHK(lat, rows[i].a[6:4])
            `CHK(len8, rows[i].a[2:0] == BL8_CODE)
            `CHK(tsel, rows[i].a[7])
            `CHK(pd_dly, rows[i].a[12] ? SLOW_PD_EXIT_DELAY : FAST_PD_EXIT_DELAY)
            `CHK(rec, {1'b0, rows[i].a[11:9]} + 4'h1)
            `CHK(tot, {2'h0, rows[i].a[11:9]} + 5'h1 + {1'b0, PRECHARGE_PERIOD})
            `CHK(order, rows[i].a[3])
            `CHK(pdsel, rows[i].a[12])
            u_ddmr_ctrl_model.idle();
        end
        cmd(3'h5, 2'h0, 13'h0000);
        `CHK(refused, 1'b1)
        `CHK(bv, 1'b0)
        cmd(3'h0, BA_EXT_ONE, 13'h1abc);
        `CHK(ext_q, 13'h1abc)
        cmd(3'h0, BA_MAIN_CFG, 13'h0132);
        `CHK(dll, 1'b1)
        prech = 1'b0;
        cmd(3'h0, BA_MAIN_CFG, 13'h0233);
        `CHK(refused, 1'b1)
        `CHK(main_q, 13'h0132)
        `CHK(dll, 1'b0)
        prech = 1'b1;
        // four-beat read cut by a read: refused, burst runs on
        cmd(3'h5, 2'h0, 13'h0000);
        cmd(3'h5, 2'h0, 13'h0002);
        `CHK(refused, 1'b1)
        `CHK(col_e, 3'h2)
        u_ddmr_ctrl_model.idle();
        // read then write with no gap; ends on 8-beat interleave
        for (int k = 0; k < 4; k++) begin
            setup(k[1], k[0]);
            burst(1'b0, k[0], 3'h1, k[1] ? 4 : 2);
            burst(1'b1, k[0], 3'h5, k[1] ? 4 : 2);
            u_ddmr_ctrl_model.idle();
            `CHK(bv, 1'b0)
        end
        cmd(3'h5, 2'h0, 13'h0000);
        cmd(3'h4, 2'h0, 13'h0000);
        `CHK(refused, 1'b1)
        cmd(3'h5, 2'h0, 13'h0004);
        `CHK(col_o, 3'h5)
        cmd(3'h6, 2'h0, 13'h0000);
        `CHK(refused, 1'b1)
        // reset in mid-burst, then a read against the cleared length field
        cmd(3'h5, 2'h0, 13'h0003);
        i_resetn = 1'b0;
        u_ddmr_ctrl_model.idle();
        `CHK(bv, 1'b0)
        `CHK(main_q, CFG_RST)
        `CHK(refused, 1'b0)
        i_resetn = 1'b1;
        cmd(3'h5, 2'h0, 13'h0000);
        `CHK(refused, 1'b1)
        `CHK(bv, 1'b0)
        stop_test();
    end
endmodule
`default_nettype wire
